// [pkg/atw_pkg.sv]
// Constants, timing counts and state type for the two-wire converter readout block.
package atw_pkg;

	// ==========================================================
	// Widths
	localparam int RES_W      = 20;
	localparam int WORD_W     = 24;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W      = 8;
	localparam int TMR_W      = 20;
	localparam int ACC_W      = 16;

	// ==========================================================
	// Clock rates in hertz
	localparam longint CLK_HZ      = 64'd20000000;
	localparam longint SYS_FAST_HZ = 64'd2457600;
	localparam longint SYS_SLOW_HZ = 64'd2252800;

	// ==========================================================
	// Times as printed: microseconds, tenths of a millisecond, or nanoseconds
	localparam longint T_UPD_FAST_US      = 64'd155;
	localparam longint T_UPD_SLOW_US      = 64'd169;
	localparam longint T_CONV_FAST_100US  = 64'd86;
	localparam longint T_CONV_SLOW_100US  = 64'd730;
	localparam longint T_CAL_FAST_100US   = 64'd2083;
	localparam longint T_CAL_SLOW_100US   = 64'd2561;
	localparam longint T_WCAL_FAST_100US  = 64'd2084;
	localparam longint T_WCAL_SLOW_100US  = 64'd2562;
	localparam longint T_SLEEP_HOLD_US    = 64'd20;
	localparam longint T_EXT_LOSS_NS      = 64'd2000;

	// ==========================================================
	// Counts in system clock cycles, and in core clock cycles
	localparam int UPD_FAST_CYC   = int'((T_UPD_FAST_US * SYS_FAST_HZ + 64'd999999) / 64'd1000000);
	localparam int UPD_SLOW_CYC   = int'((T_UPD_SLOW_US * SYS_SLOW_HZ + 64'd999999) / 64'd1000000);
	localparam int CONV_FAST_CYC  = int'(T_CONV_FAST_100US * SYS_FAST_HZ / 64'd10000);
	localparam int CONV_SLOW_CYC  = int'(T_CONV_SLOW_100US * SYS_SLOW_HZ / 64'd10000);
	localparam int CAL_FAST_CYC   = int'(T_CAL_FAST_100US * SYS_FAST_HZ / 64'd10000);
	localparam int CAL_SLOW_CYC   = int'(T_CAL_SLOW_100US * SYS_SLOW_HZ / 64'd10000);
	localparam int WCAL_FAST_CYC  = int'(T_WCAL_FAST_100US * SYS_FAST_HZ / 64'd10000);
	localparam int WCAL_SLOW_CYC  = int'(T_WCAL_SLOW_100US * SYS_SLOW_HZ / 64'd10000);
	localparam int SLEEP_HOLD_CYC = int'((T_SLEEP_HOLD_US * CLK_HZ + 64'd999999) / 64'd1000000);
	localparam int EXT_LOSS_CYC   = int'(T_EXT_LOSS_NS * CLK_HZ / 64'd1000000000);

	// Internal oscillator model: phase increment per core clock.
	localparam logic [ACC_W-1:0] OSC_INC_FAST = ACC_W'(SYS_FAST_HZ * 64'd65536 / CLK_HZ);
	localparam logic [ACC_W-1:0] OSC_INC_SLOW = ACC_W'(SYS_SLOW_HZ * 64'd65536 / CLK_HZ);

	// ==========================================================
	// Serial frame positions, counted in falling edges
	localparam logic [CNT_W-1:0] PULSE_LAST_BIT = 8'h18;
	localparam logic [CNT_W-1:0] PULSE_IDLE     = 8'h19;
	localparam logic [CNT_W-1:0] PULSE_CAL      = 8'h1A;
	localparam logic [3:0]       PAD_BITS       = 4'h0;

	typedef enum logic [1:0] {
		ST_CONV,
		ST_DATA,
		ST_CAL,
		ST_SLEEP
	} atw_state_e;

endpackage

// [verilog/atw_fifo.sv]
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module atw_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	output logic [WIDTH-1:0]      o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      count_r;
	logic [PW:0]      count_nxt;
	logic             in_ready_r;
	wire              push_w = i_in_valid && in_ready_r;
	wire              pop_w  = i_out_ready && (count_r != '0);

	// ==========================================================
	// Storage
	genvar e;
	for (e = 0; e < DEPTH; e++) begin : g_entry
		always_ff @(posedge i_clk) begin
			if (push_w && (wr_ptr_r == PW'(e))) begin
				mem_r[e] <= i_in_data;
			end
		end
	end

	// ==========================================================
	// Pointers and occupancy
	assign count_nxt = count_r + {{PW{1'b0}}, push_w} - {{PW{1'b0}}, pop_w};

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wr_ptr_r   <= '0;
			rd_ptr_r   <= '0;
			count_r    <= '0;
			in_ready_r <= 1'b0;
		end else begin
			if (push_w) begin
				wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop_w) begin
				rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r    <= count_nxt;
			in_ready_r <= (count_nxt != FULL_CNT);
		end
	end

	assign o_in_ready  = in_ready_r;
	assign o_out_data  = mem_r[rd_ptr_r];
	assign o_out_valid = (count_r != '0);
endmodule // atw_fifo
`default_nettype wire

// [verilog/atw_readout.sv]
// Conversion sequencing and two-wire ready/data readout of the converter.
`timescale 1ns/1ps
`default_nettype none
module atw_readout #(
	parameter int CONV_FAST_CYC = atw_pkg::CONV_FAST_CYC,
	parameter int CONV_SLOW_CYC = atw_pkg::CONV_SLOW_CYC,
	parameter int CAL_FAST_CYC  = atw_pkg::CAL_FAST_CYC,
	parameter int CAL_SLOW_CYC  = atw_pkg::CAL_SLOW_CYC,
	parameter int WCAL_FAST_CYC = atw_pkg::WCAL_FAST_CYC,
	parameter int WCAL_SLOW_CYC = atw_pkg::WCAL_SLOW_CYC
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_reset,
	input  wire logic                      i_sclk,
	input  wire logic                      i_ext_clk,
	input  wire logic                      i_variant_slow,
	input  wire logic [atw_pkg::RES_W-1:0] i_sample,
	input  wire logic                      i_sample_valid,
	output logic                           o_sample_ready,
	output logic                           o_rdy_dout,
	output logic                           o_osc_en,
	output logic                           o_asleep
);
	localparam int CW = atw_pkg::CNT_W;
	localparam int TW = atw_pkg::TMR_W;
	localparam logic [TW-1:0] T_CONV_F = TW'(CONV_FAST_CYC);
	localparam logic [TW-1:0] T_CONV_S = TW'(CONV_SLOW_CYC);
	localparam logic [TW-1:0] T_CAL_F  = TW'(CAL_FAST_CYC);
	localparam logic [TW-1:0] T_CAL_S  = TW'(CAL_SLOW_CYC);
	localparam logic [TW-1:0] T_WCAL_F = TW'(WCAL_FAST_CYC);
	localparam logic [TW-1:0] T_WCAL_S = TW'(WCAL_SLOW_CYC);
	localparam logic [TW-1:0] T_UPD_F  = TW'(atw_pkg::UPD_FAST_CYC);
	localparam logic [TW-1:0] T_UPD_S  = TW'(atw_pkg::UPD_SLOW_CYC);
	localparam logic [9:0]    HOLD_END = 10'(atw_pkg::SLEEP_HOLD_CYC - 1);
	localparam logic [7:0]    LOSS_END = 8'(atw_pkg::EXT_LOSS_CYC);
	localparam logic [4:0]    WORD_LEN = 5'(atw_pkg::WORD_W);

	// ==========================================================
	// Link domain: counts serial clock falling edges, gray coded
	logic          lrst_s1_r;
	logic          lrst_s2_r;
	logic [CW-1:0] fall_bin_r;
	logic [CW-1:0] fall_gray_r;
	wire  [CW-1:0] fall_bin_nxt = fall_bin_r + 1'b1;

	// The device never drives the serial clock; it counts host falling edges and samples the held level for sleep.
	always_ff @(negedge i_sclk) begin
		lrst_s1_r <= i_reset;
		lrst_s2_r <= lrst_s1_r;
	end

	always_ff @(negedge i_sclk) begin
		if (lrst_s2_r) begin
			fall_bin_r  <= '0;
			fall_gray_r <= '0;
		end else begin
			fall_bin_r  <= fall_bin_nxt;
			fall_gray_r <= fall_bin_nxt ^ (fall_bin_nxt >> 1);
		end
	end

	// ==========================================================
	// Pin synchronisers into the core domain
	logic [CW-1:0] gray_s1_r;
	logic [CW-1:0] gray_s2_r;
	logic          sclk_s1_r;
	logic          sclk_s2_r;
	logic          ext_s1_r;
	logic          ext_s2_r;
	logic          ext_s3_r;
	logic          var_s1_r;
	logic          var_s2_r;

	always_ff @(posedge i_clk) begin
		gray_s1_r <= fall_gray_r;
		gray_s2_r <= gray_s1_r;
		sclk_s1_r <= i_sclk;
		sclk_s2_r <= sclk_s1_r;
		ext_s1_r  <= i_ext_clk;
		ext_s2_r  <= ext_s1_r;
		ext_s3_r  <= ext_s2_r;
		var_s1_r  <= i_variant_slow;
		var_s2_r  <= var_s1_r;
	end

	function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
		logic [CW-1:0] b;
		b[CW-1] = g[CW-1];
		for (int k = CW - 2; k >= 0; k--) begin
			b[k] = b[k+1] ^ g[k];
		end
		return b;
	endfunction

	// ==========================================================
	// System clock: external clock when present, else internal
	logic             ext_active_r;
	logic [7:0]       loss_r;
	logic [atw_pkg::ACC_W-1:0] acc_r;
	logic             osc_en_r;
	wire              ext_rise_w = ext_s2_r && !ext_s3_r;
	wire  [atw_pkg::ACC_W-1:0] inc_w = var_s2_r ? atw_pkg::OSC_INC_SLOW : atw_pkg::OSC_INC_FAST;
	wire  [atw_pkg::ACC_W:0]   acc_sum_w = {1'b0, acc_r} + {1'b0, inc_w};
	wire              sys_tick_w = ext_active_r ? ext_rise_w : acc_sum_w[atw_pkg::ACC_W];

	// Edges on the clock pin take over timing and stop the oscillator.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ext_active_r <= 1'b0;
			loss_r       <= '0;
			acc_r        <= '0;
			osc_en_r     <= 1'b1;
		end else begin
			loss_r       <= ext_rise_w ? '0 : ((loss_r == LOSS_END) ? loss_r : loss_r + 1'b1);
			ext_active_r <= ext_rise_w || (ext_active_r && (loss_r != LOSS_END));
			acc_r        <= ext_active_r ? '0 : acc_sum_w[atw_pkg::ACC_W-1:0];
			osc_en_r     <= !ext_active_r;
		end
	end

	// ==========================================================
	// Result buffer from the filter
	logic [atw_pkg::RES_W-1:0] fifo_data_w;
	logic                      fifo_valid_w;
	logic                      pop_w;

	atw_fifo #(
		.WIDTH (atw_pkg::RES_W),
		.DEPTH (atw_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_in_data   (i_sample),
		.i_in_valid  (i_sample_valid),
		.o_in_ready  (o_sample_ready),
		.o_out_data  (fifo_data_w),
		.o_out_valid (fifo_valid_w),
		.i_out_ready (pop_w)
	);

	// ==========================================================
	// Sequencer state
	atw_pkg::atw_state_e state_r;
	atw_pkg::atw_state_e state_nxt;
	logic [TW-1:0]       timer_r;
	logic [TW-1:0]       target_r;
	logic [TW-1:0]       target_nxt;
	logic [CW-1:0]       cnt_last_r;
	logic [CW-1:0]       idx_r;
	logic [9:0]          hold_r;
	logic                sleep_cal_r;
	logic                upd_win_r;
	logic [atw_pkg::WORD_W-1:0] word_r;
	logic                rdy_r;
	logic                asleep_r;

	wire [CW-1:0] cnt_bin_w  = gray2bin(gray_s2_r);
	wire [CW-1:0] delta_w    = cnt_bin_w - cnt_last_r;
	wire          new_fall_w = (delta_w != '0);
	wire [CW-1:0] idx_sum_w  = idx_r + delta_w;
	wire [CW-1:0] idx_adv_w  = (idx_r >= atw_pkg::PULSE_CAL) ? idx_r : idx_sum_w;
	wire          end_w      = sys_tick_w && (state_r != atw_pkg::ST_SLEEP) && (timer_r == target_r - 1'b1);
	wire [TW-1:0] t_conv_w   = var_s2_r ? T_CONV_S : T_CONV_F;
	wire [TW-1:0] t_cal_w    = var_s2_r ? T_CAL_S : T_CAL_F;
	wire [TW-1:0] t_wcal_w   = var_s2_r ? T_WCAL_S : T_WCAL_F;
	wire [TW-1:0] t_upd_w    = var_s2_r ? T_UPD_S : T_UPD_F;
	wire          in_data_w  = (state_r == atw_pkg::ST_DATA);
	wire          sleep_go_w = in_data_w && sclk_s2_r && (hold_r == HOLD_END);
	wire          wake_w     = (state_r == atw_pkg::ST_SLEEP) && !sclk_s2_r;
	wire          cal_go_w   = in_data_w && new_fall_w && (idx_r < atw_pkg::PULSE_CAL)
	                           && (idx_adv_w >= atw_pkg::PULSE_CAL);
	wire          upd_w      = (state_r != atw_pkg::ST_SLEEP) && (timer_r >= target_r - t_upd_w);
	wire [4:0]    bit_pos_w  = WORD_LEN - idx_r[4:0];

	assign pop_w = end_w && fifo_valid_w;

	always_comb begin
		state_nxt  = state_r;
		target_nxt = target_r;
		unique case (state_r)
			atw_pkg::ST_CONV: begin
				if (end_w) begin
					state_nxt  = atw_pkg::ST_DATA;
					target_nxt = t_conv_w;
				end
			end
			atw_pkg::ST_DATA: begin
				if (sleep_go_w) begin
					state_nxt = atw_pkg::ST_SLEEP;
				end else if (cal_go_w) begin
					state_nxt  = atw_pkg::ST_CAL;
					target_nxt = t_cal_w;
				end else if (end_w) begin
					target_nxt = t_conv_w;
				end
			end
			atw_pkg::ST_CAL: begin
				if (end_w) begin
					state_nxt  = atw_pkg::ST_DATA;
					target_nxt = t_conv_w;
				end
			end
			atw_pkg::ST_SLEEP: begin
				if (wake_w) begin
					state_nxt  = sleep_cal_r ? atw_pkg::ST_CAL : atw_pkg::ST_CONV;
					target_nxt = sleep_cal_r ? t_wcal_w : t_conv_w;
				end
			end
		endcase
	end

	wire restart_w = (state_nxt != state_r) || end_w;

	// Continuous conversions are timed in system clock cycles only.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r  <= atw_pkg::ST_CONV;
			target_r <= T_CONV_F;
			timer_r  <= '0;
		end else begin
			state_r  <= state_nxt;
			target_r <= (state_r == atw_pkg::ST_CONV && timer_r == '0) ? t_conv_w : target_nxt;
			timer_r  <= restart_w ? '0 : (sys_tick_w ? timer_r + 1'b1 : timer_r);
		end
	end

	// ==========================================================
	// Frame tracking: pulses since the current result was posted
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cnt_last_r  <= cnt_bin_w;
			idx_r       <= '0;
			hold_r      <= '0;
			sleep_cal_r <= 1'b0;
			upd_win_r   <= 1'b0;
			word_r      <= '0;
		end else begin
			cnt_last_r <= cnt_bin_w;
			idx_r      <= end_w ? '0 : idx_adv_w;
			hold_r     <= (sclk_s2_r && hold_r != HOLD_END) ? hold_r + 1'b1 : (sclk_s2_r ? hold_r : '0);
			if (sleep_go_w) begin
				sleep_cal_r <= (idx_r >= atw_pkg::PULSE_IDLE);
			end
			upd_win_r <= upd_w;
			if (pop_w) begin
				word_r <= {fifo_data_w, atw_pkg::PAD_BITS};
			end
		end
	end

	// ==========================================================
	// Combined ready/data output
	logic rdy_nxt;

	always_comb begin
		if (!in_data_w || upd_win_r) begin
			rdy_nxt = 1'b1;
		end else if (idx_r == '0) begin
			rdy_nxt = 1'b0;
		end else if (idx_r <= atw_pkg::PULSE_LAST_BIT) begin
			rdy_nxt = word_r[bit_pos_w];
		end else begin
			rdy_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rdy_r    <= 1'b1;
			asleep_r <= 1'b0;
		end else begin
			rdy_r    <= rdy_nxt;
			asleep_r <= (state_nxt == atw_pkg::ST_SLEEP);
		end
	end

	assign o_rdy_dout = rdy_r;
	assign o_osc_en   = osc_en_r;
	assign o_asleep   = asleep_r;

	// ==========================================================
	// Checks
	atw_pkg::atw_state_e st_q_r;
	logic [CW-1:0]       idx_q_r;
	logic                upd_q_r;

	always_ff @(posedge i_clk) begin
		st_q_r  <= state_r;
		idx_q_r <= idx_r;
		upd_q_r <= upd_win_r;
	end

	wire cause_w = (idx_r != idx_q_r) || (state_r != st_q_r) || (upd_win_r != upd_q_r);

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	AST_UPDATE_HIGH: assert property (upd_win_r |=> o_rdy_dout)
		else $error("output not high in update window");
	AST_CAL_LATENCY: assert property (in_data_w && cal_go_w && !sleep_go_w |=> state_r == atw_pkg::ST_CAL
		&& target_r == $past(t_cal_w) && timer_r == '0)
		else $error("calibration start latency wrong");
	AST_WAKE_PLAIN: assert property (wake_w && !sleep_cal_r |=> state_r == atw_pkg::ST_CONV
		&& target_r == $past(t_conv_w))
		else $error("plain wake-up latency wrong");
	AST_WAKE_CAL: assert property (wake_w && sleep_cal_r |=> state_r == atw_pkg::ST_CAL
		&& target_r == $past(t_wcal_w))
		else $error("calibrated wake-up latency wrong");
	AST_READY_LOW: assert property (in_data_w && idx_r == '0 && !upd_win_r |=> !o_rdy_dout)
		else $error("ready not shown low");
	AST_OUT_CAUSE: assert property ($changed(o_rdy_dout) |-> $past(cause_w))
		else $error("output changed without cause");
	AST_OSC_STOP: assert property (ext_active_r ##1 ext_active_r |-> !o_osc_en)
		else $error("oscillator runs with external clock");
	AST_MSB_FIRST: assert property (in_data_w && idx_r == 8'h01 && !upd_win_r
		|=> o_rdy_dout == $past(word_r[atw_pkg::WORD_W-1]))
		else $error("first bit is not the MSB");
	AST_IDLE_25: assert property (in_data_w && idx_r >= atw_pkg::PULSE_IDLE |=> o_rdy_dout)
		else $error("output not idle after pulse 25");
	AST_SLEEP_HIGH: assert property (state_r == atw_pkg::ST_SLEEP ##1 state_r == atw_pkg::ST_SLEEP
		|-> o_rdy_dout && o_asleep)
		else $error("output not high while asleep");
	AST_TICK_ONLY: assert property (!sys_tick_w && !restart_w |=> $stable(timer_r))
		else $error("timer moved without system tick");
endmodule // atw_readout
`default_nettype wire

// [tb/atw_host_model.sv]
// Behavioural host that clocks the two-wire link and samples the ready/data line.
`timescale 1ns/1ps
`default_nettype none
module atw_host_model #(
	parameter int HALF_NS = 300
) (
	output logic      o_sclk,
	input  wire logic i_rdy_dout
);
	logic [23:0] word;
	logic        first_bit;
	int          unstable;

	initial begin
		o_sclk    = 1'b0;
		word      = '0;
		first_bit = 1'b1;
		unstable  = 0;
	end

	// =========================================================
	// Link tasks
	// Short bursts around reset so the link-side counter is cleared and counting again.
	task automatic reset_pulses(input int n);
		for (int i = 0; i < n; i++) begin
			#60 o_sclk = 1'b1;
			#60 o_sclk = 1'b0;
		end
	endtask

	// Bits are taken on rising edges 2 to 25; the line must not move while the clock is high.
	task automatic frame(input int n);
		logic seen;
		for (int k = 1; k <= n; k++) begin
			o_sclk = 1'b1;
			#1 seen = i_rdy_dout;
			if (k == 1) first_bit = seen;
			else if (k <= 25) word = {word[22:0], seen};
			#(HALF_NS - 2);
			if (i_rdy_dout !== seen) unstable++;
			#1 o_sclk = 1'b0;
			#HALF_NS;
		end
	endtask

	// A held high level requests sleep; it is raised right after a result appears.
	task automatic hold(input logic lvl);
		o_sclk = lvl;
	endtask
endmodule // atw_host_model
`default_nettype wire

// [tb/atw_readout_bench.sv]
// Self-checking bench of the converter readout: stream, frames, sleep, calibration, clock source.
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, act) begin checks++; if ((act) !== (exp)) begin miscompares++; \
	$display("ERROR %s expected %0h seen %0h", name, exp, act); end end
module atw_readout_bench;
	localparam int CONV_T = 600;
	localparam int CAL_T  = 900;
	localparam int WCAL_T = 950;
	localparam int CONV_S_T = 700;
	logic        i_clk;
	logic        i_reset;
	logic        i_ext_clk;
	logic        ext_on;
	logic        variant;
	logic        took;
	logic [19:0] i_sample;
	logic        i_sample_valid;
	logic        sclk;
	logic        o_sample_ready;
	logic        o_rdy_dout;
	logic        o_osc_en;
	logic        o_asleep;
	logic [19:0] exp_q[$];
	logic [19:0] last_s;
	int          miscompares;
	int          checks;
	int          seed;
	int          meas;
	int          n;

	// Slow calibration counts keep their defaults; calibration is only run in the fast variant.
	atw_readout #(.CONV_FAST_CYC(CONV_T), .CONV_SLOW_CYC(CONV_S_T), .CAL_FAST_CYC(CAL_T),
		.WCAL_FAST_CYC(WCAL_T)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk),
		.i_ext_clk(i_ext_clk), .i_variant_slow(variant), .i_sample(i_sample), .i_sample_valid(i_sample_valid),
		.o_sample_ready(o_sample_ready), .o_rdy_dout(o_rdy_dout), .o_osc_en(o_osc_en), .o_asleep(o_asleep));
	atw_host_model host_u (.o_sclk(sclk), .i_rdy_dout(o_rdy_dout));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// The external system clock runs near 2.4576 MHz only while enabled.
	initial begin
		i_ext_clk = 1'b0;
		forever begin
			#203.45;
			if (ext_on) i_ext_clk = ~i_ext_clk;
			else i_ext_clk = 1'b0;
		end
	end

	// =========================================================
	// Expectations and helpers
	function automatic int tick_cyc(input int ticks);
		return ticks * 62500 / 7680;
	endfunction
	function automatic int tick_slow(input int ticks);
		return ticks * 3125 / 352;
	endfunction
	function automatic logic near(input int seen, input int want);
		return (seen >= want - want / 50 - 8) && (seen <= want + want / 50 + 8);
	endfunction
	task automatic wait_lvl(input logic lvl, input int lim, output int cyc);
		cyc = 0;
		while (o_rdy_dout !== lvl && cyc < lim) begin
			@(posedge i_clk);
			#1;
			cyc++;
		end
		`CHK("rdy_level", lvl, o_rdy_dout)
	endtask
	task automatic read_check(input int pulses, input logic [19:0] s);
		host_u.frame(pulses);
		`CHK("ready_bit", 1'b0, host_u.first_bit)
		`CHK("rdy_stable", 0, host_u.unstable)
		if (pulses >= 25) `CHK("word", {s, 4'h0}, host_u.word)
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#5000000;
		miscompares++;
		report_and_stop();
	end

	// =========================================================
	// Main sequence
	initial begin
		miscompares = 0;
		checks = 0;
		seed = 99;
		ext_on = 1'b0;
		variant = 1'b0;
		i_reset = 1'b1;
		i_sample = '0;
		i_sample_valid = 1'b0;
		fork
			host_u.reset_pulses(4);
			repeat (10) @(posedge i_clk);
		join
		#1;
		`CHK("reset_rdy", 1'b1, o_rdy_dout)
		`CHK("reset_osc", 1'b1, o_osc_en)
		`CHK("reset_sleep", 1'b0, o_asleep)
		`CHK("reset_ready", 1'b0, o_sample_ready)
		@(posedge i_clk);
		i_reset <= 1'b0;
		// The link reset stands for two more falling edges after release; spend them before any frame.
		host_u.reset_pulses(3);
		@(posedge i_clk);
		// Corner words first, then random ones, until the buffer refuses.
		n = 0;
		i_sample_valid <= 1'b1;
		i_sample <= 20'h80000;
		repeat (14) begin
			@(negedge i_clk);
			took = o_sample_ready;
			@(posedge i_clk);
			if (i_sample_valid === 1'b1 && took === 1'b1) begin
				exp_q.push_back(i_sample);
				n++;
				i_sample <= (n == 1) ? 20'h7FFFF : 20'($random(seed));
			end
		end
		i_sample_valid <= 1'b0;
		#1;
		`CHK("fifo_taken", 8, n)
		`CHK("fifo_full", 1'b0, o_sample_ready)
		// Drain one word per result; the ninth result repeats the last word.
		for (int i = 0; i < 9; i++) begin
			wait_lvl(1'b0, 6000, meas);
			if (exp_q.size() > 0) last_s = exp_q.pop_front();
			read_check(25, last_s);
			#400 `CHK("idle_high", 1'b1, o_rdy_dout)
		end
		`CHK("fifo_empty_ready", 1'b1, o_sample_ready)
		// Without the 25th pulse the last bit stays until the update window.
		wait_lvl(1'b0, 6000, meas);
		read_check(24, last_s);
		#400 `CHK("hold_last", 1'b0, o_rdy_dout)
		wait_lvl(1'b1, 6000, meas);
		wait_lvl(1'b0, 4000, meas);
		`CHK("upd_window", 1'b1, near(meas, 3100))
		read_check(26, last_s);
		wait_lvl(1'b0, 9000, meas);
		`CHK("cal_time", 1'b1, near(meas, tick_cyc(CAL_T)))
		// Plain sleep and wake-up.
		host_u.hold(1'b1);
		repeat (500) @(posedge i_clk);
		#1 `CHK("asleep", 1'b1, o_asleep)
		`CHK("sleep_rdy", 1'b1, o_rdy_dout)
		host_u.hold(1'b0);
		wait_lvl(1'b0, 9000, meas);
		`CHK("wake_time", 1'b1, near(meas, tick_cyc(CONV_T)))
		`CHK("awake", 1'b0, o_asleep)
		// Sleep after a full read, which asks for calibration at wake-up.
		read_check(25, last_s);
		host_u.hold(1'b1);
		repeat (500) @(posedge i_clk);
		#1 `CHK("asleep_cal", 1'b1, o_asleep)
		host_u.hold(1'b0);
		wait_lvl(1'b0, 10000, meas);
		`CHK("wcal_time", 1'b1, near(meas, tick_cyc(WCAL_T)))
		// External system clock takes over the timing.
		ext_on = 1'b1;
		repeat (20) @(posedge i_clk);
		#1 `CHK("osc_off", 1'b0, o_osc_en)
		wait_lvl(1'b1, 6000, meas);
		wait_lvl(1'b0, 6000, n);
		`CHK("ext_conv", 1'b1, near(20 + meas + n, tick_cyc(CONV_T)))
		ext_on = 1'b0;
		repeat (60) @(posedge i_clk);
		#1 `CHK("osc_on", 1'b1, o_osc_en)
		// Slow variant, selected while asleep: a plain wake-up times one slow conversion.
		host_u.hold(1'b1);
		repeat (500) @(posedge i_clk);
		variant <= 1'b1;
		repeat (4) @(posedge i_clk);
		#1 `CHK("asleep_slow", 1'b1, o_asleep)
		host_u.hold(1'b0);
		wait_lvl(1'b0, 7000, meas);
		`CHK("wake_slow", 1'b1, near(meas, tick_slow(CONV_S_T)))
		report_and_stop();
	end
endmodule // atw_readout_bench
`default_nettype wire
